// ---- logic/cps_sequencer.sv ----
/*
 * cps_sequencer: power-up sequencer of a single-cell charger with an AXI4-Lite
 * register slave, battery switch control and gate-drive regulator enable.
 * Assumes comparator inputs synchronous to i_sys_clk and a single-beat master.
 */
// The implementer's own choices: the address map and the AXI4-Lite register port.
// Notes on behaviour
// - supply above release level resets registers; bus then accepted.
// - battery only and above depletion closes switch, regulator stays off.
// - overload on battery opens switch until input supply returns.
// - software disable bit opens the battery switch.
// - plugging in an input supply closes a disabled switch again.
// - regulator on only with input above release and proper sleep margin.
// - regulator waits the qualification delay, at least the minimum delay.
// - any unmet regulator condition keeps high-impedance state, regulator off.
// - input voltage checked before regulator; current limit before buck.
// - source qualified only after regulator up; failure blocks buck.
// - passing qualification sets power good flag and pulses interrupt.
// - failed poor-source check repeats every two seconds.
`timescale 1ns/100ps
module cps_sequencer
	import cps_pkg::*;
#(
	parameter int unsigned QUAL_CYC = QUAL_DELAY_CYC,
	parameter int unsigned RETRY_CYCLES = RETRY_CYC
)
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire cps_sense_t i_sense,
	input wire logic [7:0] i_awaddr,
	input wire logic i_awvalid,
	output logic o_awready,
	input wire logic [31:0] i_wdata,
	input wire logic [3:0] i_wstrb,
	input wire logic i_wvalid,
	output logic o_wready,
	output logic [1:0] o_bresp,
	output logic o_bvalid,
	input wire logic i_bready,
	input wire logic [7:0] i_araddr,
	input wire logic i_arvalid,
	output logic o_arready,
	output logic [31:0] o_rdata,
	output logic [1:0] o_rresp,
	output logic o_rvalid,
	input wire logic i_rready,
	output logic o_battery_switch_on,
	output logic o_gate_drive_regulator_en,
	output logic o_buck_en,
	output logic o_host_int
);
	localparam int TW = 25;
	localparam logic [TW-1:0] QUAL_N = TW'(QUAL_CYC);
	localparam logic [TW-1:0] RETRY_N = TW'(RETRY_CYCLES);

	cps_state_t state_q;
	logic por_ok;
	logic [31:0] ctrl_q;
	logic [1:0] wdog_q;
	logic pgood_q;
	logic latch_off_q;
	logic ship_q;
	logic switch_q;
	logic int_q;
	logic in_prev_q;
	logic in_ok;
	logic plug_in;
	logic timer_run;
	logic [TW-1:0] timer_cnt;
	logic timer_done;
	logic [7:0] aw_q;
	logic aw_have_q;
	logic [31:0] w_q;
	logic w_have_q;
	logic do_write;

	// internal logic runs when either supply passes the release level
	assign por_ok = i_sense.in_above_uvlo | i_sense.bat_above_uvlo;
	// regulator enable conditions: supply above release and sleep margin by mode
	assign in_ok = i_sense.in_above_uvlo &
		(i_sense.boost_mode ? !i_sense.in_above_bat_sleep : i_sense.in_above_bat_sleep);
	assign plug_in = i_sense.in_above_uvlo & !in_prev_q;

	// write channel: address and data taken in either order
	assign o_awready = !aw_have_q && !o_bvalid;
	assign o_wready = !w_have_q && !o_bvalid;
	assign do_write = aw_have_q && w_have_q && !o_bvalid;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			aw_q <= 8'h00;
			aw_have_q <= 1'b0;
			w_q <= 32'h00000000;
			w_have_q <= 1'b0;
			o_bvalid <= 1'b0;
			o_bresp <= RESP_OKAY;
		end
		else
		begin
			if (i_awvalid && o_awready)
			begin
				aw_q <= i_awaddr;
				aw_have_q <= 1'b1;
			end
			if (i_wvalid && o_wready)
			begin
				w_q <= i_wdata;
				w_have_q <= i_wstrb[0];
			end
			if (i_wvalid && o_wready && !i_wstrb[0])
			begin
				w_have_q <= 1'b1;
			end
			if (do_write)
			begin
				aw_have_q <= 1'b0;
				w_have_q <= 1'b0;
				o_bvalid <= 1'b1;
				o_bresp <= (aw_q == ADDR_CTRL || aw_q == ADDR_WDOG || aw_q == ADDR_STAT) ?
					RESP_OKAY : RESP_SLVERR;
			end
			else if (o_bvalid && i_bready)
			begin
				o_bvalid <= 1'b0;
			end
		end
	end

	// software registers return to defaults while supplies are low
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ctrl_q <= CTRL_RESET;
			wdog_q <= WDOG_RESET;
		end
		else if (!por_ok)
		begin
			ctrl_q <= CTRL_RESET;
			wdog_q <= WDOG_RESET;
		end
		else if (plug_in)
		begin
			ctrl_q[CTRL_SWITCH_DIS] <= 1'b0;
		end
		else if (do_write && aw_q == ADDR_CTRL)
		begin
			ctrl_q <= w_q;
			// a shipping request also turns the watchdog off
			if (w_q[CTRL_SWITCH_DIS] && w_q[CTRL_WDOG_HI:CTRL_WDOG_LO] == WDOG_OFF)
			begin
				wdog_q <= WDOG_OFF;
			end
		end
		else if (do_write && aw_q == ADDR_WDOG)
		begin
			wdog_q <= w_q[WDOG_HI:WDOG_LO];
		end
	end

	// shipping mode only when both changes arrive in one write to the control word
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			ship_q <= 1'b0;
		end
		else if (!por_ok || plug_in)
		begin
			ship_q <= 1'b0;
		end
		else if (do_write && aw_q == ADDR_CTRL && w_q[CTRL_SWITCH_DIS] &&
			w_q[CTRL_WDOG_HI:CTRL_WDOG_LO] == WDOG_OFF)
		begin
			ship_q <= 1'b1;
		end
	end

	// overload latch, released only by a new input supply
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			latch_off_q <= 1'b0;
			in_prev_q <= 1'b0;
		end
		else
		begin
			in_prev_q <= i_sense.in_above_uvlo;
			if (i_sense.sys_overload && !i_sense.in_above_uvlo)
			begin
				latch_off_q <= 1'b1;
			end
			else if (plug_in)
			begin
				latch_off_q <= 1'b0;
			end
		end
	end

	// battery switch closing conditions
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			switch_q <= 1'b0;
		end
		else
		begin
			switch_q <= por_ok && i_sense.bat_above_depl && !ctrl_q[CTRL_SWITCH_DIS] &&
				!ship_q && !latch_off_q && !(i_sense.sys_overload && !i_sense.in_above_uvlo);
		end
	end

	assign timer_run = (state_q == ST_QUAL_WAIT) || (state_q == ST_SRC_RETRY);
	assign timer_cnt = (state_q == ST_SRC_RETRY) ? RETRY_N : QUAL_N;

	cps_delay_timer #(
		.WIDTH(TW)
	) u_timer (
		.i_sys_clk(i_sys_clk),
		.i_resetn(i_resetn),
		.i_run(timer_run),
		.i_count(timer_cnt),
		.o_done(timer_done)
	);

	// power-up sequence from the input supply
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			state_q <= ST_RESET;
		end
		else if (!por_ok)
		begin
			state_q <= ST_RESET;
		end
		else if (!in_ok)
		begin
			state_q <= ST_HIZ;
		end
		else
		begin
			case (state_q)
				ST_RESET: state_q <= ST_HIZ;
				ST_HIZ: state_q <= ST_QUAL_WAIT;
				ST_QUAL_WAIT: if (timer_done) state_q <= ST_SRC_CHECK;
				ST_SRC_CHECK: state_q <= i_sense.src_good ? ST_RUN : ST_SRC_RETRY;
				ST_SRC_RETRY: if (timer_done) state_q <= ST_SRC_CHECK;
				ST_RUN: state_q <= ST_RUN;
				default: state_q <= ST_RESET;
			endcase
		end
	end

	// power good flag and host event pulse
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			pgood_q <= 1'b0;
			int_q <= 1'b0;
		end
		else
		begin
			int_q <= (state_q == ST_SRC_CHECK) && i_sense.src_good && in_ok && por_ok;
			if (state_q == ST_SRC_CHECK && i_sense.src_good && in_ok && por_ok)
			begin
				pgood_q <= 1'b1;
			end
			else if (state_q != ST_RUN && state_q != ST_SRC_CHECK)
			begin
				pgood_q <= 1'b0;
			end
		end
	end

	// register read channel
	assign o_arready = !o_rvalid;
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			o_rvalid <= 1'b0;
			o_rdata <= 32'h00000000;
			o_rresp <= RESP_OKAY;
		end
		else if (i_arvalid && o_arready)
		begin
			o_rvalid <= 1'b1;
			o_rresp <= RESP_OKAY;
			case (i_araddr)
				ADDR_CTRL: o_rdata <= ctrl_q;
				ADDR_WDOG: o_rdata <= {26'h0, wdog_q, 4'h0};
				ADDR_STAT: o_rdata <= {21'h0, state_q, 2'h0, o_buck_en, ship_q,
					latch_off_q, pgood_q, o_gate_drive_regulator_en, switch_q};
				default:
				begin
					o_rdata <= 32'h00000000;
					o_rresp <= RESP_SLVERR;
				end
			endcase
		end
		else if (o_rvalid && i_rready)
		begin
			o_rvalid <= 1'b0;
		end
	end

	assign o_battery_switch_on = switch_q;
	assign o_gate_drive_regulator_en = (state_q == ST_SRC_CHECK) || (state_q == ST_SRC_RETRY) ||
		(state_q == ST_RUN);
	assign o_buck_en = (state_q == ST_RUN) && i_sense.ilim_done;
	assign o_host_int = int_q;

	int unsigned qual_cnt;
	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			qual_cnt <= 0;
		end
		else
		begin
			qual_cnt <= (state_q == ST_QUAL_WAIT) ? qual_cnt + 1 : 0;
		end
	end

	reg_min_delay_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(o_gate_drive_regulator_en) |-> qual_cnt >= QUAL_CYC)
		else $error("regulator enabled before minimum delay");
	reg_cond_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!in_ok |=> !o_gate_drive_regulator_en)
		else $error("regulator on without supply conditions");
	switch_dis_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		ctrl_q[CTRL_SWITCH_DIS] |=> !o_battery_switch_on)
		else $error("switch closed while disabled");
	overload_open_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(i_sense.sys_overload && !i_sense.in_above_uvlo) |=> !o_battery_switch_on)
		else $error("switch not opened on overload");
	batt_only_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		(!i_sense.in_above_uvlo && i_sense.bat_above_uvlo && !o_battery_switch_on &&
		!latch_off_q && !ship_q &&
		!ctrl_q[CTRL_SWITCH_DIS] && i_sense.bat_above_depl && !i_sense.sys_overload)
		|=> o_battery_switch_on && !o_gate_drive_regulator_en)
		else $error("battery-only power up wrong");
	pgood_int_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		$rose(pgood_q) |-> o_host_int)
		else $error("power good without interrupt");
	buck_gate_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		o_buck_en |-> pgood_q && o_gate_drive_regulator_en)
		else $error("buck started before qualification");
	por_reset_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		!por_ok |=> state_q == ST_RESET && ctrl_q == CTRL_RESET)
		else $error("registers not reset on power loss");
	replug_a: assert property (@(posedge i_sys_clk) disable iff (!i_resetn)
		plug_in |=> !latch_off_q && !ship_q)
		else $error("switch not released by plug in");
endmodule

// ---- logic/cps_pkg.sv ----
/*
 * cps_pkg: register map, field positions, reset values, timing counts and the
 * state and comparator sense types for the charger power-up sequencer.
 * Assumes a 10 MHz system clock and a 32-bit AXI4-Lite register bus.
 */
package cps_pkg;
	localparam int unsigned CLK_HZ = 10000000;
	localparam int unsigned CLK_PERIOD_NS = 100;
	// qualification delay before the gate-drive regulator turns on
	localparam int unsigned QUAL_DELAY_MS = 220;
	localparam int unsigned QUAL_DELAY_MIN_MS = 100;
	localparam int unsigned QUAL_DELAY_CYC = QUAL_DELAY_MS * (CLK_HZ / 1000);
	localparam int unsigned QUAL_DELAY_MIN_CYC = QUAL_DELAY_MIN_MS * (CLK_HZ / 1000);
	// poor-source retry interval
	localparam int unsigned RETRY_S = 2;
	localparam int unsigned RETRY_CYC = RETRY_S * CLK_HZ;

	localparam logic [7:0] ADDR_CTRL = 8'h00;
	localparam logic [7:0] ADDR_WDOG = 8'h04;
	localparam logic [7:0] ADDR_STAT = 8'h08;

	// control register fields
	localparam int CTRL_SWITCH_DIS = 5;
	// image of the watchdog field in the control word, for the one-write shipping request
	localparam int CTRL_WDOG_LO = 6;
	localparam int CTRL_WDOG_HI = 7;
	localparam logic [31:0] CTRL_RESET = 32'h00000000;
	// watchdog period field, 00 = disabled
	localparam int WDOG_LO = 4;
	localparam int WDOG_HI = 5;
	localparam logic [1:0] WDOG_RESET = 2'h1;
	localparam logic [1:0] WDOG_OFF = 2'h0;
	// status register fields
	localparam int STAT_PGOOD = 2;
	localparam int STAT_SWITCH_ON = 0;
	localparam int STAT_REG_ON = 1;
	localparam int STAT_LATCH_OFF = 3;
	localparam int STAT_SHIP = 4;
	localparam int STAT_BUCK = 5;
	localparam int STAT_STATE_LO = 8;

	localparam logic [1:0] RESP_OKAY = 2'h0;
	localparam logic [1:0] RESP_SLVERR = 2'h2;

	typedef enum logic [2:0]
	{
		ST_RESET = 3'h0,
		ST_HIZ = 3'h1,
		ST_QUAL_WAIT = 3'h2,
		ST_SRC_CHECK = 3'h3,
		ST_SRC_RETRY = 3'h4,
		ST_RUN = 3'h5
	} cps_state_t;

	// analog comparator results sampled by the sequencer
	typedef struct packed {
		logic in_above_uvlo;
		logic bat_above_uvlo;
		logic bat_above_depl;
		logic in_above_bat_sleep;
		logic boost_mode;
		logic sys_overload;
		logic src_good;
		logic ilim_done;
	} cps_sense_t;
endpackage

// ---- logic/cps_delay_timer.sv ----
/*
 * cps_delay_timer: restartable up-counter that raises done, and holds it until run drops,
 * once a requested number of cycles has elapsed while run stays high.
 * Assumes a single clock domain with asynchronous active-low reset.
 */
`timescale 1ns/100ps
module cps_delay_timer
	import cps_pkg::*;
#(
	parameter int unsigned WIDTH = 25
)
(
	input wire logic i_sys_clk,
	input wire logic i_resetn,
	input wire logic i_run,
	input wire logic [WIDTH-1:0] i_count,
	output logic o_done
);
	logic [WIDTH-1:0] cnt_q;
	logic done_q;

	always_ff @(posedge i_sys_clk or negedge i_resetn)
	begin
		if (!i_resetn)
		begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end
		else if (!i_run)
		begin
			cnt_q <= '0;
			done_q <= 1'b0;
		end
		else if (!done_q)
		begin
			cnt_q <= cnt_q + 1'b1;
			done_q <= (cnt_q + 1'b1) >= i_count;
		end
	end

	assign o_done = done_q;
endmodule

// ---- testbench/cps_host_model.sv ----
/* cps_host_model: AXI4-Lite host that reaches the sequencer registers.
 * Assumes a slave on i_sys_clk; every wait is capped at 200 cycles. */
`timescale 1ns/100ps
module cps_host_model
	import cps_pkg::*;
(
	input wire logic i_sys_clk,
	input wire logic i_awready,
	input wire logic i_wready,
	input wire logic [1:0] i_bresp,
	input wire logic i_bvalid,
	input wire logic i_arready,
	input wire logic [31:0] i_rdata,
	input wire logic [1:0] i_rresp,
	input wire logic i_rvalid,
	output logic [7:0] o_awaddr = 8'h00,
	output logic o_awvalid = 1'b0,
	output logic [31:0] o_wdata = 32'h0,
	output logic [3:0] o_wstrb = 4'hF,
	output logic o_wvalid = 1'b0,
	output logic o_bready = 1'b0,
	output logic [7:0] o_araddr = 8'h00,
	output logic o_arvalid = 1'b0,
	output logic o_rready = 1'b0
);
	logic timed_out = 1'b0;

	task automatic wr(input logic [7:0] a, input logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		r = 2'h3;
		@(posedge i_sys_clk);
		o_awaddr <= a;
		o_wdata <= d;
		o_awvalid <= 1'b1;
		o_wvalid <= 1'b1;
		o_bready <= 1'b1;
		while (!done && n < 200)
		begin
			@(posedge i_sys_clk);
			n++;
			if (o_awvalid && i_awready)
				o_awvalid <= 1'b0;
			if (o_wvalid && i_wready)
				o_wvalid <= 1'b0;
			if (o_bready && i_bvalid)
			begin
				r = i_bresp;
				o_bready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			timed_out = 1'b1;
	endtask

	task automatic rd(input logic [7:0] a, output logic [31:0] d, output logic [1:0] r);
		int n;
		logic done;
		n = 0;
		done = 1'b0;
		d = 32'h0;
		r = 2'h3;
		@(posedge i_sys_clk);
		o_araddr <= a;
		o_arvalid <= 1'b1;
		o_rready <= 1'b1;
		while (!done && n < 200)
		begin
			@(posedge i_sys_clk);
			n++;
			if (o_arvalid && i_arready)
				o_arvalid <= 1'b0;
			if (o_rready && i_rvalid)
			begin
				d = i_rdata;
				r = i_rresp;
				o_rready <= 1'b0;
				done = 1'b1;
			end
		end
		if (!done)
			timed_out = 1'b1;
	endtask

	// switch disable and watchdog image at 00 in one control write
	task automatic ship(output logic [1:0] r);
		wr(ADDR_CTRL, 32'h20, r);
	endtask
endmodule

// ---- testbench/tb_charger_power_up_sequencer.sv ----
/* tb_charger_power_up_sequencer: random and directed checks of the sequencer.
 * Assumes cps_host_model on the register bus and shortened delay counts. */
`timescale 1ns/100ps
module tb_charger_power_up_sequencer
	import cps_pkg::*;
;
	localparam int unsigned QC = 1200;
	localparam int unsigned RC = 50;
	logic clk = 1'b0;
	logic resetn = 1'b0;
	cps_sense_t sense = '0;
	int n_mismatch = 0;
	int n_tests = 0;
	int n;
	logic [31:0] d, v;
	logic [1:0] r;
	logic [7:0] awaddr, araddr;
	logic [31:0] wdata, rdata;
	logic [3:0] wstrb;
	logic [1:0] bresp, rresp;
	logic awvalid, awready, wvalid, wready, bvalid, bready, arvalid, arready, rvalid, rready;
	logic sw_on, reg_en, buck_en, host_int;

	always #50 clk = ~clk;

	cps_sequencer #(.QUAL_CYC(QC), .RETRY_CYCLES(RC)) DUT (.i_sys_clk(clk), .i_resetn(resetn),
		.i_sense(sense), .i_awaddr(awaddr), .i_awvalid(awvalid), .o_awready(awready),
		.i_wdata(wdata), .i_wstrb(wstrb), .i_wvalid(wvalid), .o_wready(wready),
		.o_bresp(bresp), .o_bvalid(bvalid), .i_bready(bready), .i_araddr(araddr),
		.i_arvalid(arvalid), .o_arready(arready), .o_rdata(rdata), .o_rresp(rresp),
		.o_rvalid(rvalid), .i_rready(rready), .o_battery_switch_on(sw_on),
		.o_gate_drive_regulator_en(reg_en), .o_buck_en(buck_en), .o_host_int(host_int));

	cps_host_model host (.i_sys_clk(clk), .i_awready(awready), .i_wready(wready),
		.i_bresp(bresp), .i_bvalid(bvalid), .i_arready(arready), .i_rdata(rdata),
		.i_rresp(rresp), .i_rvalid(rvalid), .o_awaddr(awaddr), .o_awvalid(awvalid),
		.o_wdata(wdata), .o_wstrb(wstrb), .o_wvalid(wvalid), .o_bready(bready),
		.o_araddr(araddr), .o_arvalid(arvalid), .o_rready(rready));

	task automatic conclude;
		$display("tests=%0d mismatches=%0d", n_tests, n_mismatch);
		if (n_mismatch == 0 && n_tests > 0)
			$display("SIMULATION PASSED");
		else
			$display("SIMULATION FAILED");
		$finish;
	endtask

	task automatic chk(input logic [31:0] got, input logic [31:0] exp);
		n_tests++;
		if (got !== exp)
		begin
			n_mismatch++;
			$display("ERROR t=%0t got=%h exp=%h", $time, got, exp);
		end
		if (host.timed_out)
		begin
			n_mismatch++;
			conclude();
		end
	endtask

	task automatic cyc(input int k);
		repeat (k) @(posedge clk);
	endtask

	function automatic logic reg_exp(input logic sleep, input logic boost);
		return sleep ^ boost;
	endfunction

	initial
	begin
		void'($urandom(32'hfeb08e2e));
		cyc(10);
		resetn <= 1'b1;
		sense.bat_above_uvlo <= 1'b1;
		sense.bat_above_depl <= 1'b1;
		host.rd(ADDR_CTRL, d, r);
		chk(d, CTRL_RESET);
		host.rd(ADDR_WDOG, d, r);
		chk(32'(d[WDOG_HI:WDOG_LO]), 32'(WDOG_RESET));
		host.rd(8'h0C, d, r);
		chk(d, 32'h0);
		chk(32'(r), 32'(RESP_SLVERR));
		v = $urandom() & 32'hFFFFFFDF;
		host.wr(ADDR_CTRL, v, r);
		host.rd(ADDR_CTRL, d, r);
		chk(d, v);
		chk(32'({sw_on, reg_en}), 32'h2);
		$display("test registers and battery power-up done");
		@(posedge clk);
		sense.sys_overload <= 1'b1;
		cyc(3);
		chk(32'(sw_on), 32'h0);
		sense.sys_overload <= 1'b0;
		cyc(5 + $urandom_range(15));
		chk(32'(sw_on), 32'h0);
		sense.in_above_uvlo <= 1'b1;
		cyc(3);
		chk(32'(sw_on), 32'h1);
		sense.in_above_uvlo <= 1'b0;
		host.wr(ADDR_CTRL, 32'hE0, r);
		cyc(3);
		chk(32'(sw_on), 32'h0);
		host.rd(ADDR_STAT, d, r);
		chk(32'(d[STAT_SHIP]), 32'h0);
		host.ship(r);
		cyc(3);
		chk(32'({r, sw_on}), 32'({RESP_OKAY, 1'b0}));
		host.rd(ADDR_STAT, d, r);
		chk(32'(d[STAT_SHIP]), 32'h1);
		host.rd(ADDR_WDOG, d, r);
		chk(32'(d[WDOG_HI:WDOG_LO]), 32'(WDOG_OFF));
		sense.in_above_uvlo <= 1'b1;
		cyc(3);
		chk(32'(sw_on), 32'h1);
		$display("test battery switch done");
		for (int k = 0; k < 4; k++)
		begin
			sense.in_above_uvlo <= 1'b0;
			cyc(3);
			sense.in_above_bat_sleep <= k[0];
			sense.boost_mode <= k[1];
			sense.src_good <= 1'b0;
			sense.in_above_uvlo <= 1'b1;
			n = 0;
			while (reg_en !== 1'b1 && n < QC + 50)
			begin
				@(posedge clk);
				n++;
			end
			chk(32'(reg_en), 32'(reg_exp(k[0], k[1])));
			if (reg_exp(k[0], k[1]))
			begin
				chk(32'(n >= QC && n <= QC + 5), 32'h1);
				chk(32'(buck_en), 32'h0);
				sense.in_above_bat_sleep <= ~k[0];
				cyc(3);
				chk(32'(reg_en), 32'h0);
			end
		end
		$display("test regulator enable done");
		sense.in_above_uvlo <= 1'b0;
		cyc(3);
		sense.in_above_bat_sleep <= 1'b1;
		sense.boost_mode <= 1'b0;
		sense.ilim_done <= 1'b1;
		sense.in_above_uvlo <= 1'b1;
		cyc(QC + 20);
		chk(32'({reg_en, buck_en, host_int}), 32'h4);
		cyc($urandom_range(RC));
		sense.src_good <= 1'b1;
		n = 0;
		while (host_int !== 1'b1 && n < RC + 20)
		begin
			@(posedge clk);
			n++;
		end
		chk(32'(n <= RC + 10), 32'h1);
		@(posedge clk);
		chk(32'(host_int), 32'h0);
		host.rd(ADDR_STAT, d, r);
		chk(32'({d[STAT_PGOOD], buck_en}), 32'h3);
		sense.ilim_done <= 1'b0;
		cyc(2);
		chk(32'(buck_en), 32'h0);
		$display("test source qualification done");
		v = ($urandom() & 32'hFFFFFFDF) | 32'h00000001;
		host.wr(ADDR_CTRL, v, r);
		sense <= '0;
		cyc(3);
		chk(32'({sw_on, reg_en}), 32'h0);
		host.rd(ADDR_STAT, d, r);
		chk(32'({d[STAT_PGOOD], d[10:8]}), 32'h0);
		sense.bat_above_uvlo <= 1'b1;
		host.rd(ADDR_CTRL, d, r);
		chk(d, CTRL_RESET);
		host.rd(ADDR_WDOG, d, r);
		chk(32'(d[WDOG_HI:WDOG_LO]), 32'(WDOG_RESET));
		$display("test power-on reset done");
		conclude();
	end
endmodule
